// file: core/dotc_consts.svh
// Constants for the digital output trigger control block
`ifndef DOTC_CONSTS_SVH
`define DOTC_CONSTS_SVH
`define DOTC_PORT_W 8
`define DOTC_NUM_CH 5
`define DOTC_CH_W 3
`define DOTC_CNT_W 32
`define DOTC_CLK_CH 3'h3
`define DOTC_IRQ_CH 3'h4
`define DOTC_EXTERNAL_CLOCK_CHANNEL_ALIAS 3'h7
`define DOTC_CLK_BIT 8'h01
`define DOTC_ZERO8 8'h00
`define DOTC_ZERO32 32'h00000000
`define DOTC_ONE32 32'h00000001
`endif

// file: core/dotc_pkg.sv
// Types shared by the digital output trigger control block
`include "dotc_consts.svh"
`default_nettype none
package dotc_pkg;
  typedef enum logic [1:0] {
    DOTC_START_NONE = 2'h0,
    DOTC_START_CMD  = 2'h1,
    DOTC_START_DIG  = 2'h2
  } dotc_start_t;
  typedef enum logic [1:0] {
    DOTC_STOP_NONE = 2'h0,
    DOTC_STOP_CMD  = 2'h1,
    DOTC_STOP_TC   = 2'h2,
    DOTC_STOP_DIG  = 2'h3
  } dotc_stop_t;
  typedef enum logic [1:0] {
    DOTC_TM_NONE     = 2'h0,
    DOTC_TM_RATE_EXT = 2'h1,
    DOTC_TM_DIGITAL  = 2'h2
  } dotc_timing_t;
  typedef enum logic [2:0] {
    DOTC_IDLE  = 3'h0,
    DOTC_ARMED = 3'h1,
    DOTC_DELAY = 3'h2,
    DOTC_RUN   = 3'h3,
    DOTC_DRAIN = 3'h4
  } dotc_state_t;
  typedef struct packed {
    logic [`DOTC_CH_W-1:0]   ch;
    logic [`DOTC_PORT_W-1:0] mask;
    logic [`DOTC_PORT_W-1:0] pattern;
    logic                    match_ne;
  } dotc_evt_t;
endpackage : dotc_pkg
`default_nettype wire

// file: core/dotc_sync.sv
// Two-flop synchroniser for the digital input ports
`include "dotc_consts.svh"
`default_nettype none
module dotc_sync (
  input  wire logic                                  mclk,
  input  wire logic                                  resetn,
  input  wire logic [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] d,
  output logic      [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] q
);
  logic [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] meta_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : dotc_sync
`default_nettype wire

// file: core/dotc_evt.sv
// Masked pattern comparator for one digital event
`include "dotc_consts.svh"
`default_nettype none
module dotc_evt (
  input  wire dotc_pkg::dotc_evt_t                   evt,
  input  wire logic [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] pins,
  output logic                                       hit
);
  logic [`DOTC_PORT_W-1:0] data;
  logic                    same;

  always_comb begin
    data = `DOTC_ZERO8;
    for (int i = 0; i < `DOTC_NUM_CH; i++) begin
      if (evt.ch == i[`DOTC_CH_W-1:0]) begin
        data = pins[i*`DOTC_PORT_W +: `DOTC_PORT_W];
      end
    end
    same = ((data & evt.mask) == evt.pattern);
    hit  = evt.match_ne ? !same : same;
  end
endmodule : dotc_evt
`default_nettype wire

// file: core/dotc_ctrl.sv
// Trigger, pacing and stop sequencing for the digital output task
`include "dotc_consts.svh"
`default_nettype none
// How it works
// - A digital timing event acts as an external rate clock pacing writes.
// - The irq input cannot be start or stop source while it clocks.
// - External clock is channel 3; an alias code also selects it.
// - Each event ANDs mask with channel data, then compares with pattern.
// - Clock: one mask bit, not-equal; pattern 0 rising, 1 falling.
// - A task using one channel for timing and trigger is rejected.
// - Start may be none, command or digital pattern condition.
// - Command start runs as soon as parameters are loaded.
// - Equal triggers on exact match, not-equal on any difference.
// - Only irq channel triggers at once; others sample at each tick.
// - Post-trigger delay of 0 to 2^32-1 timing pulses before writing.
// - Digital start is refused without an external timing source.
// - Stop may be none, command, terminal count or digital.
// - Terminal count stops after every buffer word is written once.
// - Digital stop keeps writing until the condition holds, then ends after stop_delay more writes.
// - Interrupt mode writes one sample at every timing event.
// - Polled mode writes one scan per status request until stop.
// - Pre-trigger delay must be a whole multiple of scan channels.
// - External rate clock uses rising edge unless falling is selected.
module dotc_ctrl (
  input  wire logic                                  mclk,
  input  wire logic                                  resetn,
  input  wire logic [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] di_pins,
  input  wire dotc_pkg::dotc_timing_t                timing_sel,
  input  wire logic                                  ext_fall,
  input  wire dotc_pkg::dotc_evt_t                   timing_evt,
  input  wire dotc_pkg::dotc_start_t                 start_sel,
  input  wire dotc_pkg::dotc_evt_t                   start_evt,
  input  wire logic [`DOTC_CNT_W-1:0]                start_delay,
  input  wire dotc_pkg::dotc_stop_t                  stop_sel,
  input  wire dotc_pkg::dotc_evt_t                   stop_evt,
  input  wire logic [`DOTC_CNT_W-1:0]                stop_delay,
  input  wire logic [`DOTC_CH_W-1:0]                 scan_chans,
  input  wire logic [`DOTC_CNT_W-1:0]                buf_len,
  input  wire logic                                  poll_mode,
  input  wire logic                                  cmd_go,
  input  wire logic                                  cmd_stop,
  input  wire logic                                  cmd_status,
  output logic                                       task_busy,
  output logic                                       task_reject,
  output logic                                       task_done,
  output logic                                       out_write,
  output logic      [`DOTC_CNT_W-1:0]                out_index,
  output dotc_pkg::dotc_state_t                      task_state
);

  // ----------------------------------------------------------------
  // Channel alias resolution
  // ----------------------------------------------------------------
  function automatic logic [`DOTC_CH_W-1:0] resolve_ch(input logic [`DOTC_CH_W-1:0] ch);
    resolve_ch = (ch == `DOTC_EXTERNAL_CLOCK_CHANNEL_ALIAS) ? `DOTC_CLK_CH : ch;
  endfunction : resolve_ch

  // ----------------------------------------------------------------
  // Input sampling and event evaluation
  // ----------------------------------------------------------------
  logic [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] pins_s;
  dotc_pkg::dotc_evt_t                  tm_evt;
  dotc_pkg::dotc_evt_t                  st_evt;
  dotc_pkg::dotc_evt_t                  sp_evt;
  logic                                 tm_hit;
  logic                                 st_hit;
  logic                                 sp_hit;
  logic                                 tm_hit_q;
  logic                                 tick;
  logic                                 st_ok;
  logic                                 sp_ok;
  dotc_pkg::dotc_state_t                state_q;
  logic [`DOTC_CNT_W-1:0]               dly_q;
  logic [`DOTC_CNT_W-1:0]               wr_cnt_q;
  logic                                 reject;
  logic                                 clash;
  logic                                 pace;
  logic                                 wr_fire;
  logic                                 tc_hit;
  logic                                 active;

  dotc_sync u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      (di_pins),
    .q      (pins_s)
  );

  // Rate mode builds the single-bit not-equal event on the clock channel
  always_comb begin
    tm_evt = timing_evt;
    tm_evt.ch = resolve_ch(timing_evt.ch);
    if (timing_sel == dotc_pkg::DOTC_TM_RATE_EXT) begin
      tm_evt.ch       = `DOTC_CLK_CH;
      tm_evt.mask     = `DOTC_CLK_BIT;
      tm_evt.pattern  = ext_fall ? `DOTC_CLK_BIT : `DOTC_ZERO8;
      tm_evt.match_ne = 1'b1;
    end
    st_evt    = start_evt;
    st_evt.ch = resolve_ch(start_evt.ch);
    sp_evt    = stop_evt;
    sp_evt.ch = resolve_ch(stop_evt.ch);
  end

  dotc_evt u_tm (
    .evt          (tm_evt),
    .pins         (pins_s),
    .hit          (tm_hit)
  );

  dotc_evt u_st (
    .evt          (st_evt),
    .pins         (pins_s),
    .hit          (st_hit)
  );

  dotc_evt u_sp (
    .evt          (sp_evt),
    .pins         (pins_s),
    .hit          (sp_hit)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tm_hit_q <= 1'b0;
    end else begin
      tm_hit_q <= tm_hit;
    end
  end

  // A tick is the moment the timing condition becomes true, i.e. the clock edge
  assign tick = (timing_sel != dotc_pkg::DOTC_TM_NONE) && tm_hit && !tm_hit_q;

  // Triggers on ordinary channels are only looked at on sample ticks
  assign st_ok = st_hit && ((st_evt.ch == `DOTC_IRQ_CH) || tick);
  assign sp_ok = sp_hit && ((sp_evt.ch == `DOTC_IRQ_CH) || tick);

  // ----------------------------------------------------------------
  // Task validation at load time
  // ----------------------------------------------------------------
  always_comb begin
    clash = 1'b0;
    if (timing_sel != dotc_pkg::DOTC_TM_NONE) begin
      if (start_sel == dotc_pkg::DOTC_START_DIG && st_evt.ch == tm_evt.ch) begin
        clash = 1'b1;
      end
      if (stop_sel == dotc_pkg::DOTC_STOP_DIG && sp_evt.ch == tm_evt.ch) begin
        clash = 1'b1;
      end
    end
    reject = clash;
    if (start_sel == dotc_pkg::DOTC_START_DIG && timing_sel == dotc_pkg::DOTC_TM_NONE) begin
      reject = 1'b1;
    end
    if (stop_sel == dotc_pkg::DOTC_STOP_DIG) begin
      if (scan_chans == '0 || (stop_delay % scan_chans) != `DOTC_ZERO32) begin
        reject = 1'b1;
      end
    end
    if (stop_sel == dotc_pkg::DOTC_STOP_TC && buf_len == `DOTC_ZERO32) begin
      reject = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pacing of output writes
  // ----------------------------------------------------------------
  assign active = (state_q == dotc_pkg::DOTC_RUN) || (state_q == dotc_pkg::DOTC_DRAIN);
  assign pace   = poll_mode ? cmd_status : tick;
  assign wr_fire = (active && pace) ||
                   (state_q == dotc_pkg::DOTC_DELAY && tick && dly_q == `DOTC_ONE32);
  assign tc_hit = (stop_sel == dotc_pkg::DOTC_STOP_TC) && wr_fire &&
                  (wr_cnt_q + `DOTC_ONE32 == buf_len);

  // ----------------------------------------------------------------
  // Task sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= dotc_pkg::DOTC_IDLE;
      dly_q   <= `DOTC_ZERO32;
    end else if (state_q != dotc_pkg::DOTC_IDLE && cmd_stop) begin
      state_q <= dotc_pkg::DOTC_IDLE;
    end else begin
      case (state_q)
        dotc_pkg::DOTC_IDLE: begin
          if (cmd_go && !reject) begin
            if (start_sel == dotc_pkg::DOTC_START_DIG) begin
              state_q <= dotc_pkg::DOTC_ARMED;
            end else begin
              state_q <= dotc_pkg::DOTC_RUN;
            end
          end
        end
        dotc_pkg::DOTC_ARMED: begin
          if (st_ok) begin
            dly_q <= start_delay;
            if (start_delay == `DOTC_ZERO32) begin
              state_q <= dotc_pkg::DOTC_RUN;
            end else begin
              state_q <= dotc_pkg::DOTC_DELAY;
            end
          end
        end
        dotc_pkg::DOTC_DELAY: begin
          if (tick) begin
            dly_q <= dly_q - `DOTC_ONE32;
            if (tc_hit) begin
              state_q <= dotc_pkg::DOTC_IDLE;
            end else if (dly_q == `DOTC_ONE32) begin
              state_q <= dotc_pkg::DOTC_RUN;
            end
          end
        end
        dotc_pkg::DOTC_RUN: begin
          if (tc_hit) begin
            state_q <= dotc_pkg::DOTC_IDLE;
          end else if (stop_sel == dotc_pkg::DOTC_STOP_DIG && sp_ok) begin
            dly_q <= stop_delay;
            if (stop_delay == `DOTC_ZERO32) begin
              state_q <= dotc_pkg::DOTC_IDLE;
            end else begin
              state_q <= dotc_pkg::DOTC_DRAIN;
            end
          end
        end
        dotc_pkg::DOTC_DRAIN: begin
          if (tc_hit) begin
            state_q <= dotc_pkg::DOTC_IDLE;
          end else if (wr_fire) begin
            dly_q <= dly_q - `DOTC_ONE32;
            if (dly_q == `DOTC_ONE32) begin
              state_q <= dotc_pkg::DOTC_IDLE;
            end
          end
        end
        default: begin
          state_q <= dotc_pkg::DOTC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write strobe and sample index
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_write <= 1'b0;
      out_index <= `DOTC_ZERO32;
      wr_cnt_q  <= `DOTC_ZERO32;
    end else begin
      out_write <= wr_fire;
      if (state_q == dotc_pkg::DOTC_IDLE && cmd_go) begin
        wr_cnt_q <= `DOTC_ZERO32;
      end else if (wr_fire) begin
        out_index <= wr_cnt_q;
        wr_cnt_q  <= wr_cnt_q + `DOTC_ONE32;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Done stays up until the next load so software can poll it late
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      task_reject <= 1'b0;
      task_done   <= 1'b0;
    end else begin
      if (state_q == dotc_pkg::DOTC_IDLE && cmd_go) begin
        task_reject <= reject;
        task_done   <= 1'b0;
      end else if (state_q != dotc_pkg::DOTC_IDLE) begin
        if (cmd_stop || tc_hit) begin
          task_done <= 1'b1;
        end else if (state_q == dotc_pkg::DOTC_RUN && stop_sel == dotc_pkg::DOTC_STOP_DIG &&
                     sp_ok && stop_delay == `DOTC_ZERO32) begin
          task_done <= 1'b1;
        end else if (state_q == dotc_pkg::DOTC_DRAIN && wr_fire && dly_q == `DOTC_ONE32) begin
          task_done <= 1'b1;
        end
      end
    end
  end

  assign task_busy  = (state_q != dotc_pkg::DOTC_IDLE);
  assign task_state = state_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_load;
    state_q == dotc_pkg::DOTC_IDLE && cmd_go;
  endsequence

  sequence s_running_free;
    state_q == dotc_pkg::DOTC_RUN && !cmd_stop;
  endsequence

  a_clash_refused: assert property (s_load ##0 clash |=> task_reject && !task_busy)
    else $error("shared timing and trigger channel not refused");

  a_irq_clock_refused: assert property (s_load ##0 timing_sel != dotc_pkg::DOTC_TM_NONE &&
      tm_evt.ch == `DOTC_IRQ_CH && ((start_sel == dotc_pkg::DOTC_START_DIG &&
      st_evt.ch == `DOTC_IRQ_CH) || (stop_sel == dotc_pkg::DOTC_STOP_DIG &&
      sp_evt.ch == `DOTC_IRQ_CH)) |=> task_reject)
    else $error("irq clock also used as trigger");

  a_ext_clock_chan: assert property (timing_sel == dotc_pkg::DOTC_TM_RATE_EXT |->
      tm_evt.ch == `DOTC_CLK_CH && tm_evt.match_ne && tm_evt.pattern[0] == ext_fall)
    else $error("external clock not on clock channel");

  a_pace_tick: assert property (s_running_free ##0 !poll_mode ##0 tick |=>
      out_write ##1 !out_write)
    else $error("tick did not give one write");

  a_cmd_start: assert property (s_load ##0 !reject ##0
      start_sel == dotc_pkg::DOTC_START_CMD |=> state_q == dotc_pkg::DOTC_RUN)
    else $error("command start not immediate");

  a_dig_start_wait: assert property (state_q == dotc_pkg::DOTC_ARMED && !st_ok |=>
      !out_write)
    else $error("write before start condition");

  a_delay_no_write: assert property (state_q == dotc_pkg::DOTC_DELAY &&
      dly_q > `DOTC_ONE32 |=> !out_write)
    else $error("write during trigger delay");

  // A one-word terminal count may end the task on the very first write
  a_delay_expiry: assert property (state_q == dotc_pkg::DOTC_DELAY && tick &&
      dly_q == `DOTC_ONE32 && !cmd_stop && !tc_hit |=> out_write && task_busy)
    else $error("no first write on delay expiry");

  a_cmd_stop_ends: assert property (task_busy && cmd_stop |=> !task_busy && task_done)
    else $error("stop command did not end task");

  a_tc_stop: assert property (tc_hit && !cmd_stop |=> !task_busy && task_done
      && out_index == buf_len - `DOTC_ONE32)
    else $error("terminal count did not end task");

  a_poll_scan: assert property (s_running_free ##0 poll_mode ##0 cmd_status |=>
      out_write)
    else $error("status request gave no scan");

  a_sampled_trigger: assert property (st_ok && st_evt.ch != `DOTC_IRQ_CH |-> tick)
    else $error("sampled trigger off a tick");

  a_pre_multiple: assert property (s_load ##0 stop_sel == dotc_pkg::DOTC_STOP_DIG &&
      scan_chans != '0 && (stop_delay % scan_chans) != `DOTC_ZERO32 |=> task_reject)
    else $error("pre-trigger delay not multiple of scan");

  a_no_time_dig: assert property (s_load ##0 start_sel == dotc_pkg::DOTC_START_DIG &&
      timing_sel == dotc_pkg::DOTC_TM_NONE |=> task_reject && !task_busy)
    else $error("digital start accepted without timing");

endmodule : dotc_ctrl
`default_nettype wire

// file: verif/dotc_src_model.sv
// Behavioural model of the external clock and trigger sources on the input pins
`include "dotc_consts.svh"
`default_nettype none
module dotc_src_model (
  input  wire logic [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] lvl,
  output logic      [`DOTC_NUM_CH*`DOTC_PORT_W-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_b = 1'h0;

  // ----------------------------------------------------------------
  // Clock source
  // ----------------------------------------------------------------
  // Stands low between frames; each pulse is one full 800 ns period
  task automatic pulses(input int n);
    repeat (n) begin
      #400;
      clk_b = 1'h1;
      #400;
      clk_b = 1'h0;
    end
  endtask : pulses

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Trigger levels are held by the caller for whole periods, never glitched
  always_comb begin
    pins = lvl;
    pins[`DOTC_CLK_CH*`DOTC_PORT_W] = clk_b;
  end
endmodule : dotc_src_model
`default_nettype wire

// file: verif/digital_output_trigger_control_tb_top.sv
// Self-checking bench for the digital output trigger control block
`include "dotc_consts.svh"
`default_nettype none
module digital_output_trigger_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   mclk, resetn, ext_fall, poll_mode;
  logic                   cmd_go, cmd_stop, cmd_status;
  logic [39:0]            lvl, di_pins;
  dotc_pkg::dotc_timing_t timing_sel;
  dotc_pkg::dotc_start_t  start_sel;
  dotc_pkg::dotc_stop_t   stop_sel;
  dotc_pkg::dotc_evt_t    tev, sev, pev;
  logic [31:0]            start_delay, stop_delay, buf_len, out_index, last_idx;
  logic [2:0]             scan_chans;
  dotc_pkg::dotc_state_t  task_state;
  logic                   task_busy, task_reject, task_done, out_write;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  int                     n_wr = 0;
  int                     base;

  dotc_src_model src (.lvl(lvl), .pins(di_pins));

  dotc_ctrl uut (
    .mclk(mclk), .resetn(resetn), .di_pins(di_pins), .timing_sel(timing_sel),
    .ext_fall(ext_fall), .timing_evt(tev), .start_sel(start_sel), .start_evt(sev),
    .start_delay(start_delay), .stop_sel(stop_sel), .stop_evt(pev),
    .stop_delay(stop_delay), .scan_chans(scan_chans), .buf_len(buf_len),
    .poll_mode(poll_mode), .cmd_go(cmd_go), .cmd_stop(cmd_stop),
    .cmd_status(cmd_status), .task_busy(task_busy), .task_reject(task_reject),
    .task_done(task_done), .out_write(out_write), .out_index(out_index),
    .task_state(task_state)
  );

  // ----------------------------------------------------------------
  // Clock and write monitor
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (out_write === 1'h1) begin
      n_wr <= n_wr + 1;
      last_idx <= out_index;
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk_v

  // Commands are one-cycle pulses: 0 go, 1 stop, other status
  task automatic strobe(input int k);
    @(negedge mclk);
    case (k)
      0: cmd_go = 1'h1;
      1: cmd_stop = 1'h1;
      default: cmd_status = 1'h1;
    endcase
    @(negedge mclk);
    {cmd_go, cmd_stop, cmd_status} = 3'h0;
  endtask : strobe

  // Frames of clock pulses, then room for the 3-cycle pin latency
  task automatic ticks(input int n);
    src.pulses(n);
    repeat (6) @(negedge mclk);
  endtask : ticks

  task automatic defaults();
    timing_sel = dotc_pkg::DOTC_TM_RATE_EXT;
    start_sel = dotc_pkg::DOTC_START_CMD;
    stop_sel = dotc_pkg::DOTC_STOP_CMD;
    {tev, sev, pev} = '0;
    {ext_fall, poll_mode} = 2'h0;
    {start_delay, stop_delay, buf_len} = '0;
    scan_chans = 3'h1;
    base = n_wr;
  endtask : defaults

  task automatic chk_run(input logic [31:0] st, input int wr, input logic [31:0] idx);
    chk_v("task_state", st, {29'h0, task_state});
    chk_v("task_busy", {31'h0, st != 32'h0}, {31'h0, task_busy});
    chk_v("write_count", wr, n_wr - base);
    if (wr > 0) chk_v("out_index", idx, last_idx);
  endtask : chk_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {cmd_go, cmd_stop, cmd_status} = 3'h0;
    lvl = '0;
    defaults();
    resetn = 1'h0;
    repeat (4) @(negedge mclk);
    chk_v("reset_outputs", 32'h0,
          {25'h0, task_busy, task_reject, task_done, out_write, task_state});
    resetn = 1'h1;
    @(negedge mclk);

    for (int i = 0; i < 6; i++) begin
      defaults();
      case (i)
        0: begin
          timing_sel = dotc_pkg::DOTC_TM_DIGITAL;
          start_sel  = dotc_pkg::DOTC_START_DIG;
          tev.ch     = 3'h7;
          sev.ch     = 3'h3;
        end
        1: begin
          timing_sel = dotc_pkg::DOTC_TM_DIGITAL;
          stop_sel   = dotc_pkg::DOTC_STOP_DIG;
          tev.ch     = 3'h4;
          pev.ch     = 3'h4;
        end
        2: begin
          timing_sel = dotc_pkg::DOTC_TM_NONE;
          start_sel  = dotc_pkg::DOTC_START_DIG;
          sev.ch     = 3'h1;
        end
        3: begin
          stop_sel   = dotc_pkg::DOTC_STOP_DIG;
          pev.ch     = 3'h1;
          scan_chans = 3'h0;
        end
        4: begin
          stop_sel   = dotc_pkg::DOTC_STOP_DIG;
          scan_chans = 3'h2;
          stop_delay = 32'h3;
        end
        default: stop_sel = dotc_pkg::DOTC_STOP_TC;
      endcase
      strobe(0);
      chk_v("task_reject", 32'h1, {31'h0, task_reject});
      chk_v("task_state", 32'h0, {29'h0, task_state});
    end
    $display("test refusals done");

    defaults();
    stop_sel = dotc_pkg::DOTC_STOP_TC;
    buf_len = 32'h3;
    strobe(0);
    chk_run(32'h3, 0, 32'h0);
    ticks(5);
    chk_run(32'h0, 3, 32'h2);
    chk_v("task_done", 32'h1, {31'h0, task_done});
    $display("test terminal count done");

    defaults();
    timing_sel = dotc_pkg::DOTC_TM_DIGITAL;
    tev = '{ch: 3'h7, mask: `DOTC_CLK_BIT, pattern: 8'h01, match_ne: 1'h1};
    start_sel = dotc_pkg::DOTC_START_DIG;
    sev = '{ch: 3'h1, mask: 8'hF0, pattern: 8'h50, match_ne: 1'h0};
    start_delay = 32'h2;
    lvl[8 +: 8] = 8'h4F;
    strobe(0);
    chk_v("task_reject", 32'h0, {31'h0, task_reject});
    ticks(3);
    chk_run(32'h1, 0, 32'h0);
    lvl[8 +: 8] = 8'h5C;
    ticks(1);
    chk_run(32'h2, 0, 32'h0);
    ticks(1);
    chk_run(32'h2, 0, 32'h0);
    ticks(1);
    chk_run(32'h3, 1, 32'h0);
    ticks(2);
    chk_run(32'h3, 3, 32'h2);
    strobe(1);
    chk_run(32'h0, 3, 32'h2);
    lvl = '0;
    $display("test post trigger done");

    defaults();
    stop_sel = dotc_pkg::DOTC_STOP_DIG;
    pev = '{ch: 3'h4, mask: 8'h80, pattern: 8'h80, match_ne: 1'h0};
    ext_fall = 1'h1;
    {scan_chans, stop_delay} = {3'h2, 32'h2};
    strobe(0);
    ticks(2);
    chk_run(32'h3, 2, 32'h1);
    lvl[32 +: 8] = 8'hFF;
    repeat (5) @(negedge mclk);
    chk_run(32'h4, 2, 32'h1);
    ticks(3);
    chk_run(32'h0, 4, 32'h3);
    lvl = '0;
    $display("test pre trigger done");

    defaults();
    poll_mode = 1'h1;
    strobe(0);
    repeat (3) strobe(2);
    // The last write is only counted by the monitor at the following edge
    @(negedge mclk);
    chk_run(32'h3, 3, 32'h2);
    strobe(1);
    chk_run(32'h0, 3, 32'h2);
    $display("test polled done");
    complete_run();
  end

  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
endmodule : digital_output_trigger_control_tb_top
`default_nettype wire
